// ---- bench/test_video_input_format_frontend.sv ----
// Bench joining the source end and the front end over the video link
`timescale 1ns/1ps
module test_video_input_format_frontend;
   logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
   logic                fdir, pdir, hvf, mux, lnk, core_valid, fir_int;
   logic [2:0]          tflag;
   logic [7:0]          paddr;
   logic [31:0]         pwdata, prdata, rd;
   vid_pkg::col_t       luma, blue, red;
   vid_pkg::key_t       key;
   vid_pkg::stage_t     stg;
   vid_pkg::input_fmt_t fmt;
   int                  err_total, n_compared, nw;
   vid_link_if vid_link_if_i (.pclk(pclk), .presetn(presetn));
   video_source_end video_source_end_i (.pclk(pclk), .presetn(presetn), .link(vid_link_if_i.source),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   video_input_format_frontend video_input_format_frontend_i (.pclk(pclk), .presetn(presetn),
      .link(vid_link_if_i.device), .filter_direction_select(fdir), .port_direction_select(pdir),
      .timing_flag_output_enable(hvf), .input_multiplex_select(mux), .link_count_select(lnk),
      .timing_flag_in(tflag), .core_luma(luma), .core_blue(blue), .core_red(red), .core_key(key),
      .core_valid(core_valid), .fir_interpolate(fir_int), .fir_follows_stage(stg), .active_format(fmt));
   vid_link_props vid_link_props_i (.pclk(pclk), .presetn(presetn), .b_col_src(vid_link_if_i.b_col_src),
      .sample_valid(vid_link_if_i.sample_valid), .dev_flag(vid_link_if_i.dev_flag),
      .dev_flag_oe(vid_link_if_i.dev_flag_oe), .contention(vid_link_if_i.contention), .timing_flag_in(tflag),
      .port_direction_select(pdir), .core_luma(luma), .core_key(key), .core_valid(core_valid),
      .fir_interpolate(fir_int), .fir_follows_stage(stg), .active_format(fmt));
   // Clock
   initial begin
      pclk = 1'h0;
      forever #2.5 pclk = ~pclk;
   end
   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task complete_run;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : complete_run
   // One APB transfer; the request holds until pready is seen at an edge
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      // No wait limit here: only the watchdog may end a stalled access
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      rd = prdata;
      serr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   // Key write launches the word; channels and the one-cycle valid follow one edge later
   task word(input logic [12:0] a, input logic [12:0] b, input logic [12:0] c, input logic [10:0] k);
      apb(1'h1, vid_pkg::OFF_P1, {19'h0, a});
      apb(1'h1, vid_pkg::OFF_P2, {19'h0, b});
      apb(1'h1, vid_pkg::OFF_P3, {19'h0, c});
      apb(1'h1, vid_pkg::OFF_KEY, {21'h0, k});
      nw++;
      @(posedge pclk);
      #1;
   endtask : word
   // Device flag enable drops before the source may drive bit 12 again
   task cfg(input logic f, input logic p, input logic h, input logic m, input logic l, input logic [1:0] w);
      @(posedge pclk);
      fdir <= f;
      pdir <= p;
      hvf <= 1'h0;
      mux <= m;
      lnk <= l;
      apb(1'h1, vid_pkg::OFF_CTRL, {28'h0, w, h, p});
      @(posedge pclk);
      hvf <= h;
      repeat (4) @(posedge pclk);
   endtask : cfg
   function automatic logic [12:0] emb(input logic [12:0] v, input int w);
      return (w == 2) ? v : (w == 1) ? {3'h0, v[7:0], 2'h0} : {3'h0, v[9:0]};
   endfunction : emb
   initial begin
      {presetn, psel, penable, pwrite, fdir, pdir, hvf, mux, lnk} = 9'h0;
      {paddr, pwdata, tflag} = 43'h0;
      {err_total, n_compared, nw} = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, vid_pkg::OFF_CTRL, 32'h0);
      check("ctrl", rd, {28'h0, vid_pkg::CTRL_RESET});
      check("stage", stg, vid_pkg::STG_MATRIX_KEY);
      check("fmt", fmt, vid_pkg::FMT_DUAL);
      apb(1'h0, 8'h40, 32'h0);
      check("slverr", serr, 32'h1);
      check("unmapped", rd, 32'h0);
      $display("test reset done");
      // Every width code through the plain path
      for (int i = 0; i < 3; i++) begin
         cfg(1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 2'(i));
         word(13'h1ABC, 13'h0123, 13'h1FFF, 11'h5A5);
         check("valid", core_valid, 32'h1);
         check("luma", luma, emb(13'h1ABC, i));
         check("blue", blue, emb(13'h0123, i));
         check("red", red, emb(13'h1FFF, i));
         check("key", key, 11'(emb(13'h05A5, i)));
      end
      $display("test widths done");
      cfg(1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 2'h2);
      word(13'h1ABC, 13'h0123, 13'h1FFF, 11'h5A5);
      check("interp", fir_int, 32'h1);
      check("ilu", luma, 13'h02BC);
      check("ikey", key, 11'h1A5);
      cfg(1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 2'h0);
      word(13'h0155, 13'h02AA, 13'h0333, 11'h0CC);
      check("bluma", luma, 13'h0155);
      check("bred", red, 13'h0333);
      check("bkey", key, 11'h0CC);
      check("aidle", vid_link_if_i.a_col[0], 13'h0);
      tflag <= 3'h5;
      cfg(1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 2'h2);
      word(13'h1FFF, 13'h1FFF, 13'h1FFF, 11'h7FF);
      check("fluma", luma, 13'h0FFF);
      check("fh", vid_link_if_i.a_col[0][12], 32'h1);
      check("fv", vid_link_if_i.a_col[1][12], 32'h0);
      check("ff", vid_link_if_i.a_col[2][12], 32'h1);
      apb(1'h0, vid_pkg::OFF_STAT, 32'h0);
      check("sflag", rd[18:16], 32'h5);
      $display("test ports done");
      // Dual then single link groups of four words
      for (int l = 0; l < 2; l++) begin
         cfg(1'h0, 1'h0, 1'h0, 1'h0, 1'(l), 2'h0);
         for (int j = 1; j < 5; j++) begin
            word(13'(13'h100 + j), 13'h0, 13'h0, 11'(11'h010 + j));
            check("mvalid", core_valid, 32'((l == 1) ? (j == 4) : (j % 2 == 0)));
         end
         check("mluma", luma, (l == 1) ? 13'h102 : 13'h104);
         check("mblue", blue, 13'h101);
         check("mred", red, 13'h103);
         check("mkey", key, (l == 1) ? 11'h104 : 11'h014);
      end
      apb(1'h0, vid_pkg::OFF_STAT, 32'h0);
      check("count", rd[15:0], 16'(nw));
      $display("test links done");
      complete_run();
   end
   // Watchdog well past the expected run length
   initial begin
      #50000;
      err_total++;
      complete_run();
   end
endmodule : test_video_input_format_frontend

// ---- bench/vid_link_props.sv ----
// Concurrent checks on the video link and the front end outputs
`timescale 1ns/1ps
module vid_link_props (
   // Clock and reset
   input wire logic                pclk,
   input wire logic                presetn,
   // Link
   input wire vid_pkg::col_bus_t   b_col_src,
   input wire logic                sample_valid,
   input wire logic [2:0]          dev_flag,
   input wire logic [2:0]          dev_flag_oe,
   input wire logic [2:0]          contention,
   // Front end
   input wire logic [2:0]          timing_flag_in,
   input wire logic                port_direction_select,
   input wire vid_pkg::col_t       core_luma,
   input wire vid_pkg::key_t       core_key,
   input wire logic                core_valid,
   input wire logic                fir_interpolate,
   input wire vid_pkg::stage_t     fir_follows_stage,
   input wire vid_pkg::input_fmt_t active_format
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // A word on the ports, then its channels one cycle on
   sequence s_word; sample_valid && active_format == vid_pkg::FMT_NONMUX; endsequence
   sequence s_out; core_valid; endsequence
   // Both ends on bit 12 would fight on the wire
   a_one_driver: assert property (contention == 3'h0) else $error("bit 12 driven twice");
   a_flag_group: assert property (dev_flag_oe == 3'h0 || dev_flag_oe == 3'h7) else $error("flag enables split");
   a_flag_follow: assert property (dev_flag_oe[0] && $past(dev_flag_oe[0]) |-> dev_flag == $past(timing_flag_in))
      else $error("flag lags input");
   a_out_cause: assert property (core_valid |-> $past(sample_valid)) else $error("output without word");
   a_nonmux_word: assert property (s_word |=> s_out) else $error("plain word not passed");
   a_decim_place: assert property (!fir_interpolate |-> fir_follows_stage == vid_pkg::STG_MATRIX_KEY)
      else $error("decimation misplaced");
   a_interp_place: assert property (fir_interpolate |-> fir_follows_stage == vid_pkg::STG_BLANK_OFFS)
      else $error("interpolation misplaced");
   a_interp_trim: assert property (core_valid && fir_interpolate |-> core_luma[12:10] == 3'h0 && !core_key[10])
      else $error("upper bits kept");
   a_idle_side: assert property (sample_valid && !port_direction_select |-> b_col_src == '0)
      else $error("idle side not low");
endmodule : vid_link_props

// ---- hw/port_select.sv ----
// Maps device ports onto the four core inputs and trims sample width
`timescale 1ns/1ps
module port_select (
   // Port groups
   input  wire vid_pkg::col_bus_t a_col,
   input  wire vid_pkg::key_t     a_key,
   input  wire vid_pkg::col_bus_t b_col,
   input  wire vid_pkg::key_t     b_key,
   // Active configuration
   input  wire logic              port_dir,
   input  wire logic              flags_out,
   input  wire logic              interp,
   // Core inputs
   output vid_pkg::col_t          core_one,
   output vid_pkg::col_t          core_two,
   output vid_pkg::col_t          core_three,
   output vid_pkg::key_t          core_four
);
   vid_pkg::col_bus_t sel;
   vid_pkg::key_t     key;

   // Side choice, flag bit masking and interpolation width limit
   always_comb begin
      sel = port_dir ? b_col : a_col;
      key = port_dir ? b_key : a_key;
      for (int i = 0; i < vid_pkg::NUM_COL; i++) begin
         // Bit 12 is an output then, so its wire level is not video
         if (!port_dir && flags_out) begin
            sel[i][vid_pkg::TOP_BIT] = 1'b0;
         end
         if (interp) begin
            sel[i] = vid_pkg::col_t'(sel[i][vid_pkg::SAMPLE_W-1:0]);
         end
      end
      if (interp) begin
         key = vid_pkg::key_t'(key[vid_pkg::SAMPLE_W-1:0]);
      end
   end

   assign core_one   = sel[0];
   assign core_two   = sel[1];
   assign core_three = sel[2];
   assign core_four  = key;
endmodule : port_select

// ---- hw/vid_link_if.sv ----
// Parallel video port bundle between upstream source and front end
`timescale 1ns/1ps
interface vid_link_if (
   input wire logic pclk,
   input wire logic presetn
);
   vid_pkg::col_bus_t     a_col_src;
   vid_pkg::key_t         a_key_src;
   vid_pkg::col_bus_t     b_col_src;
   vid_pkg::key_t         b_key_src;
   logic [2:0]            src_top_oe;
   logic                  sample_valid;
   logic [2:0]            dev_flag;
   logic [2:0]            dev_flag_oe;
   vid_pkg::col_bus_t     a_col;
   logic [2:0]            contention;

   // Resolve bit 12 of side A ports; an undriven wire reads low
   always_comb begin
      for (int i = 0; i < vid_pkg::NUM_COL; i++) begin
         a_col[i] = a_col_src[i];
         a_col[i][vid_pkg::TOP_BIT] = dev_flag_oe[i] ? dev_flag[i] : (src_top_oe[i] & a_col_src[i][vid_pkg::TOP_BIT]);
      end
   end

   assign contention = dev_flag_oe & src_top_oe;

   modport source (
      input  pclk,
      input  a_col,
      output a_col_src,
      output a_key_src,
      output b_col_src,
      output b_key_src,
      output src_top_oe,
      output sample_valid
   );

   modport device (
      input  a_col,
      input  a_key_src,
      input  b_col_src,
      input  b_key_src,
      input  sample_valid,
      output dev_flag,
      output dev_flag_oe
   );
endinterface : vid_link_if

// ---- hw/vid_pkg.sv ----
// Shared constants and types for the video input front end and its source
package vid_pkg;
   // Port geometry
   localparam int COL_W    = 13;
   localparam int KEY_W    = 11;
   localparam int SAMPLE_W = 10;
   localparam int NUM_COL  = 3;
   localparam int TOP_BIT  = 12;
   localparam int EMB8_SHIFT = 2;
   localparam int FLAG_H   = 0;
   localparam int FLAG_V   = 1;
   localparam int FLAG_F   = 2;

   typedef logic [COL_W-1:0]              col_t;
   typedef logic [KEY_W-1:0]              key_t;
   typedef logic [NUM_COL-1:0][COL_W-1:0] col_bus_t;

   // Source register map (byte addresses)
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_P1   = 8'h04;
   localparam logic [7:0] OFF_P2   = 8'h08;
   localparam logic [7:0] OFF_P3   = 8'h0C;
   localparam logic [7:0] OFF_KEY  = 8'h10;
   localparam logic [7:0] OFF_STAT = 8'h14;

   // Control register fields
   localparam int CTRL_PDIR_BIT  = 0;
   localparam int CTRL_HVF_BIT   = 1;
   localparam int CTRL_WIDTH_LSB = 2;
   localparam int CTRL_W         = 4;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;
   localparam int STAT_FLAG_LSB  = 16;

   typedef enum logic [1:0] {WID_10 = 2'h0, WID_8 = 2'h1, WID_13 = 2'h2} width_t;
   typedef enum logic [1:0] {PH0 = 2'h0, PH1 = 2'h1, PH2 = 2'h3, PH3 = 2'h2} phase_t;
   typedef enum logic [1:0] {FMT_DUAL = 2'h0, FMT_SINGLE = 2'h1, FMT_NONMUX = 2'h2} input_fmt_t;
   typedef enum logic [2:0] {
      STG_DEMUX      = 3'h0,
      STG_BLANK_OFFS = 3'h1,
      STG_FIR        = 3'h2,
      STG_MATRIX_KEY = 3'h3,
      STG_OUT_OFFS   = 3'h4,
      STG_CLIP       = 3'h5,
      STG_OUT_MUX    = 3'h6
   } stage_t;
endpackage : vid_pkg

// ---- hw/video_input_format_frontend.sv ----
// Device end: input format front end with demultiplexer and flag outputs
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
module video_input_format_frontend (
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Video ports
   vid_link_if.device            link,
   // Static configuration
   input  wire logic             filter_direction_select,
   input  wire logic             port_direction_select,
   input  wire logic             timing_flag_output_enable,
   input  wire logic             input_multiplex_select,
   input  wire logic             link_count_select,
   // Timing flags for bit 12 of side A
   input  wire logic [2:0]       timing_flag_in,
   // Demultiplexed channels
   output vid_pkg::col_t         core_luma,
   output vid_pkg::col_t         core_blue,
   output vid_pkg::col_t         core_red,
   output vid_pkg::key_t         core_key,
   output logic                  core_valid,
   // Path arrangement
   output logic                  fir_interpolate,
   output vid_pkg::stage_t       fir_follows_stage,
   output vid_pkg::input_fmt_t   active_format
);
   // Active configuration
   logic                 dir_ff;
   logic                 nxt_dir;
   logic                 pdir_ff;
   logic                 nxt_pdir;
   logic                 hvf_ff;
   logic                 nxt_hvf;
   vid_pkg::input_fmt_t  fmt_ff;
   vid_pkg::input_fmt_t  nxt_fmt;
   vid_pkg::stage_t      slot_ff;
   vid_pkg::stage_t      nxt_slot;
   logic                 cfg_load;
   // Demultiplexer state
   vid_pkg::phase_t      phase_ff;
   vid_pkg::phase_t      nxt_phase;
   vid_pkg::col_t        luma_ff;
   vid_pkg::col_t        nxt_luma;
   vid_pkg::col_t        blue_ff;
   vid_pkg::col_t        nxt_blue;
   vid_pkg::col_t        red_ff;
   vid_pkg::col_t        nxt_red;
   vid_pkg::key_t        key_ff;
   vid_pkg::key_t        nxt_key;
   logic                 valid_ff;
   logic                 nxt_valid;
   logic                 grp_end;
   // Flag drive
   logic [2:0]           flag_ff;
   logic [2:0]           nxt_flag;
   logic [2:0]           flag_oe_ff;
   logic [2:0]           nxt_flag_oe;
   // Core inputs
   vid_pkg::col_t        core_one;
   vid_pkg::col_t        core_two;
   vid_pkg::col_t        core_three;
   vid_pkg::key_t        core_four;

   // Gray step of the word phase
   function automatic vid_pkg::phase_t step_phase(input vid_pkg::phase_t p);
      unique case (p)
         vid_pkg::PH0: step_phase = vid_pkg::PH1;
         vid_pkg::PH1: step_phase = vid_pkg::PH2;
         vid_pkg::PH2: step_phase = vid_pkg::PH3;
         vid_pkg::PH3: step_phase = vid_pkg::PH0;
      endcase
   endfunction : step_phase

   port_select u_port_select (
      .a_col      (link.a_col),
      .a_key      (link.a_key_src),
      .b_col      (link.b_col_src),
      .b_key      (link.b_key_src),
      .port_dir   (pdir_ff),
      .flags_out  (hvf_ff),
      .interp     (dir_ff),
      .core_one   (core_one),
      .core_two   (core_two),
      .core_three (core_three),
      .core_four  (core_four)
   );

   // Demultiplexer: one word per sample_valid, grouped by the gray phase
   always_comb begin
      nxt_phase = phase_ff;
      nxt_luma  = luma_ff;
      nxt_blue  = blue_ff;
      nxt_red   = red_ff;
      nxt_key   = key_ff;
      nxt_valid = 1'b0;
      grp_end   = 1'b0;
      if (link.sample_valid) begin
         unique case (fmt_ff)
            vid_pkg::FMT_NONMUX: begin
               // Already parallel: every word carries all four channels
               nxt_luma  = core_one;
               nxt_blue  = core_two;
               nxt_red   = core_three;
               nxt_key   = core_four;
               nxt_valid = 1'b1;
               grp_end   = 1'b1;
            end
            vid_pkg::FMT_DUAL: begin
               // 4:2:2 on input one (Cb Y Cr Y), key stream on input four
               nxt_phase = step_phase(phase_ff);
               unique case (phase_ff)
                  vid_pkg::PH0: nxt_blue = core_one;
                  vid_pkg::PH2: nxt_red  = core_one;
                  vid_pkg::PH1, vid_pkg::PH3: begin
                     nxt_luma  = core_one;
                     nxt_key   = core_four;
                     nxt_valid = 1'b1;
                  end
               endcase
               grp_end = (phase_ff == vid_pkg::PH3);
            end
            vid_pkg::FMT_SINGLE: begin
               // One link at word rate: Cb Y Cr K, all on input one
               nxt_phase = step_phase(phase_ff);
               unique case (phase_ff)
                  vid_pkg::PH0: nxt_blue = core_one;
                  vid_pkg::PH1: nxt_luma = core_one;
                  vid_pkg::PH2: nxt_red  = core_one;
                  vid_pkg::PH3: begin
                     nxt_key   = vid_pkg::key_t'(core_one);
                     nxt_valid = 1'b1;
                  end
               endcase
               grp_end = (phase_ff == vid_pkg::PH3);
            end
            default: begin
               // Illegal format code: resynchronise at the group start
               nxt_phase = vid_pkg::PH0;
               grp_end   = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_ff <= vid_pkg::PH0;
         luma_ff  <= '0;
         blue_ff  <= '0;
         red_ff   <= '0;
         key_ff   <= '0;
         valid_ff <= 1'b0;
      end else begin
         phase_ff <= nxt_phase;
         luma_ff  <= nxt_luma;
         blue_ff  <= nxt_blue;
         red_ff   <= nxt_red;
         key_ff   <= nxt_key;
         valid_ff <= nxt_valid;
      end
   end

   // Configuration is taken only at a group edge or while idle at its start,
   // so a half-received sample never mixes two formats
   assign cfg_load = grp_end || ((phase_ff == vid_pkg::PH0) && !link.sample_valid);

   always_comb begin
      nxt_dir  = dir_ff;
      nxt_pdir = pdir_ff;
      nxt_hvf  = hvf_ff;
      nxt_fmt  = fmt_ff;
      nxt_slot = slot_ff;
      if (cfg_load) begin
         nxt_dir  = filter_direction_select;
         nxt_pdir = port_direction_select;
         nxt_hvf  = timing_flag_output_enable;
         if (input_multiplex_select) begin
            nxt_fmt = vid_pkg::FMT_NONMUX;
         end else if (link_count_select) begin
            nxt_fmt = vid_pkg::FMT_SINGLE;
         end else begin
            nxt_fmt = vid_pkg::FMT_DUAL;
         end
         // Filters sit right after blanking when interpolating, else after the matrix
         nxt_slot = filter_direction_select ? vid_pkg::STG_BLANK_OFFS : vid_pkg::STG_MATRIX_KEY;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_ff  <= 1'b0;
         pdir_ff <= 1'b0;
         hvf_ff  <= 1'b0;
         fmt_ff  <= vid_pkg::FMT_DUAL;
         slot_ff <= vid_pkg::STG_MATRIX_KEY;
      end else begin
         dir_ff  <= nxt_dir;
         pdir_ff <= nxt_pdir;
         hvf_ff  <= nxt_hvf;
         fmt_ff  <= nxt_fmt;
         slot_ff <= nxt_slot;
      end
   end

   // Flag drive on bit 12 of side A ports one to three
   always_comb begin
      nxt_flag    = timing_flag_in;
      nxt_flag_oe = {3{~pdir_ff & hvf_ff}};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_ff    <= 3'h0;
         flag_oe_ff <= 3'h0;
      end else begin
         flag_ff    <= nxt_flag;
         flag_oe_ff <= nxt_flag_oe;
      end
   end

   assign link.dev_flag    = flag_ff;
   assign link.dev_flag_oe = flag_oe_ff;

   // Outputs straight from flops
   assign core_luma         = luma_ff;
   assign core_blue         = blue_ff;
   assign core_red          = red_ff;
   assign core_key          = key_ff;
   assign core_valid        = valid_ff;
   // Full 13-bit words reach the core when decimating, except bit 12 of side A while it carries flags; width trim is only for interpolation
   assign fir_interpolate   = dir_ff;
   assign fir_follows_stage = slot_ff;
   assign active_format     = fmt_ff;
endmodule : video_input_format_frontend

// ---- hw/video_source_end.sv ----
// Upstream end: APB-programmed source that embeds samples onto the ports
`timescale 1ns/1ps
module video_source_end (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Video ports
   vid_link_if.source       link,
   // APB slave
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr
);
   logic [vid_pkg::CTRL_W-1:0] ctrl_ff;
   logic [vid_pkg::CTRL_W-1:0] nxt_ctrl;
   vid_pkg::col_t              val_ff [3];
   vid_pkg::col_t              nxt_val [3];
   vid_pkg::col_bus_t          a_col_ff;
   vid_pkg::col_bus_t          nxt_a_col;
   vid_pkg::col_bus_t          b_col_ff;
   vid_pkg::col_bus_t          nxt_b_col;
   vid_pkg::key_t              a_key_ff;
   vid_pkg::key_t              nxt_a_key;
   vid_pkg::key_t              b_key_ff;
   vid_pkg::key_t              nxt_b_key;
   logic [2:0]                 top_oe_ff;
   logic [2:0]                 nxt_top_oe;
   logic                       valid_ff;
   logic                       nxt_valid;
   logic [15:0]                sent_ff;
   logic [15:0]                nxt_sent;
   logic [31:0]                prdata_ff;
   logic [31:0]                nxt_prdata;
   logic                       wr_acc;
   logic                       mapped;
   logic                       pdir;
   logic                       hvf;
   vid_pkg::width_t            width;
   vid_pkg::col_bus_t          emb;
   vid_pkg::col_t              key_emb;
   logic [2:0]                 seen_flags;

   // Places a sample into a 13-bit port, all other bits low
   function automatic vid_pkg::col_t embed(input vid_pkg::col_t v, input vid_pkg::width_t w);
      unique case (w)
         vid_pkg::WID_8:  embed = vid_pkg::col_t'({v[7:0], 2'h0});
         vid_pkg::WID_10: embed = vid_pkg::col_t'(v[vid_pkg::SAMPLE_W-1:0]);
         default:         embed = v;
      endcase
   endfunction : embed

   assign pdir    = ctrl_ff[vid_pkg::CTRL_PDIR_BIT];
   assign hvf     = ctrl_ff[vid_pkg::CTRL_HVF_BIT];
   assign width   = vid_pkg::width_t'(ctrl_ff[vid_pkg::CTRL_WIDTH_LSB +: 2]);
   assign wr_acc  = psel && penable && pwrite;
   assign mapped  = (paddr == vid_pkg::OFF_CTRL) || (paddr == vid_pkg::OFF_P1) || (paddr == vid_pkg::OFF_P2) ||
                    (paddr == vid_pkg::OFF_P3) || (paddr == vid_pkg::OFF_KEY) || (paddr == vid_pkg::OFF_STAT);
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // Flag levels the device shows on bit 12 of side A
   always_comb begin
      for (int i = 0; i < vid_pkg::NUM_COL; i++) begin
         seen_flags[i] = link.a_col[i][vid_pkg::TOP_BIT];
      end
   end

   // Register writes; a key write launches one word onto the ports
   always_comb begin
      nxt_ctrl  = ctrl_ff;
      nxt_val   = val_ff;
      nxt_a_col = a_col_ff;
      nxt_b_col = b_col_ff;
      nxt_a_key = a_key_ff;
      nxt_b_key = b_key_ff;
      nxt_valid = 1'b0;
      nxt_sent  = sent_ff;
      emb       = '0;
      key_emb   = '0;
      // Bit 12 of side A is released while the device owns it
      nxt_top_oe = {3{~(~pdir & hvf)}};
      for (int i = 0; i < vid_pkg::NUM_COL; i++) begin
         emb[i] = embed(val_ff[i], width);
      end
      key_emb = embed(vid_pkg::col_t'(pwdata[vid_pkg::COL_W-1:0]), width);
      if (wr_acc && mapped) begin
         unique case (paddr)
            vid_pkg::OFF_CTRL: nxt_ctrl   = pwdata[vid_pkg::CTRL_W-1:0];
            vid_pkg::OFF_P1:   nxt_val[0] = pwdata[vid_pkg::COL_W-1:0];
            vid_pkg::OFF_P2:   nxt_val[1] = pwdata[vid_pkg::COL_W-1:0];
            vid_pkg::OFF_P3:   nxt_val[2] = pwdata[vid_pkg::COL_W-1:0];
            vid_pkg::OFF_KEY: begin
               // The idle side is held low
               nxt_a_col = pdir ? '0 : emb;
               nxt_b_col = pdir ? emb : '0;
               nxt_a_key = pdir ? '0 : key_emb[vid_pkg::KEY_W-1:0];
               nxt_b_key = pdir ? key_emb[vid_pkg::KEY_W-1:0] : '0;
               nxt_valid = 1'b1;
               nxt_sent  = sent_ff + 16'h0001;
            end
            default: nxt_ctrl = ctrl_ff;
         endcase
      end
   end

   // Read data captured in the setup phase, so it is stable through access
   always_comb begin
      nxt_prdata = prdata_ff;
      if (psel && !penable) begin
         nxt_prdata = 32'h0000_0000;
         unique case (paddr)
            vid_pkg::OFF_CTRL: nxt_prdata = 32'(ctrl_ff);
            vid_pkg::OFF_P1:   nxt_prdata = 32'(val_ff[0]);
            vid_pkg::OFF_P2:   nxt_prdata = 32'(val_ff[1]);
            vid_pkg::OFF_P3:   nxt_prdata = 32'(val_ff[2]);
            vid_pkg::OFF_STAT: nxt_prdata = {13'h0000, seen_flags, sent_ff};
            default:           nxt_prdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff   <= vid_pkg::CTRL_RESET;
         val_ff    <= '{default: '0};
         a_col_ff  <= '0;
         b_col_ff  <= '0;
         a_key_ff  <= '0;
         b_key_ff  <= '0;
         top_oe_ff <= 3'h0;
         valid_ff  <= 1'b0;
         sent_ff   <= 16'h0000;
         prdata_ff <= 32'h0000_0000;
      end else begin
         ctrl_ff   <= nxt_ctrl;
         val_ff    <= nxt_val;
         a_col_ff  <= nxt_a_col;
         b_col_ff  <= nxt_b_col;
         a_key_ff  <= nxt_a_key;
         b_key_ff  <= nxt_b_key;
         top_oe_ff <= nxt_top_oe;
         valid_ff  <= nxt_valid;
         sent_ff   <= nxt_sent;
         prdata_ff <= nxt_prdata;
      end
   end

   assign link.a_col_src    = a_col_ff;
   assign link.b_col_src    = b_col_ff;
   assign link.a_key_src    = a_key_ff;
   assign link.b_key_src    = b_key_ff;
   assign link.src_top_oe   = top_oe_ff;
   assign link.sample_valid = valid_ff;
   assign prdata            = prdata_ff;
endmodule : video_source_end
